// ---- fhs_pkg.sv ----
`default_nettype none
package fhs_pkg;
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_SENSE = 8'h0c;
  localparam logic [7:0] OFF_UPTIME = 8'h10;
  localparam logic [7:0] OFF_LOG_SEL = 8'h14;
  localparam logic [7:0] OFF_LOG_TS = 8'h18;
  localparam logic [7:0] OFF_LOG_CODE = 8'h1c;
  localparam logic [7:0] OFF_POS_REF = 8'h20;
  localparam int ST_HALT = 0;
  localparam int ST_SUP_WARN = 1;
  localparam int ST_SUP_FAULT = 2;
  localparam int ST_OVERDRIVE = 3;
  localparam int ST_TEMP_WARN = 4;
  localparam int ST_TEMP_ERR = 5;
  localparam int ST_CUR_FAULT = 6;
  localparam int ST_VOLT_ERR = 7;
  localparam int ST_ERR_STATE = 8;
  localparam int ST_LIMIT = 9;
  localparam logic [7:0] CMD_HOMING = 8'h20;
  localparam logic [7:0] CMD_PREPOS = 8'h21;
  localparam logic [7:0] CMD_HALT = 8'h22;
  localparam logic [7:0] CMD_ACK = 8'h24;
  localparam logic [7:0] CMD_GRASP = 8'h25;
  localparam logic [7:0] CMD_RELEASE = 8'h26;
  localparam logic [7:0] CMD_OVERDRIVE = 8'h30;
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_DENIED = 8'h01;
  localparam logic [7:0] RES_ACK_REFUSED = 8'h02;
  localparam logic [7:0] RES_UNKNOWN = 8'h03;
  localparam logic [7:0] TEMP_WARN_C = 8'h41;
  localparam logic [7:0] TEMP_ERR_C = 8'h46;
  localparam logic [9:0] V_FAULT_LO = 10'h0c8;
  localparam logic [9:0] V_WARN_LO = 10'h0dc;
  localparam logic [9:0] V_WARN_HI = 10'h104;
  localparam logic [9:0] V_FAULT_HI = 10'h118;
  localparam logic [9:0] V_HYST = 10'h005;
  localparam int EV_N = 5;
  localparam int EV_HALT = 0;
  localparam int EV_TWARN = 1;
  localparam int EV_TERR = 2;
  localparam int EV_CUR = 3;
  localparam int EV_OVD = 4;
  localparam int LOG_DEPTH = 16;
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- fhs_supervisor.sv ----
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module fhs_supervisor #(
  parameter int MS_CYCLES = fhs_pkg::MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic [7:0] temp_c,
  input wire logic [9:0] supply_dv,
  input wire logic overload,
  input wire logic limit_cross,
  input wire logic cmd_fail_ack,
  input wire logic homed_valid,
  input wire logic [31:0] homed_pos,
  input wire logic tod_valid,
  input wire logic [31:0] tod_ms,
  output logic drive_en,
  output logic motion_valid,
  output logic [7:0] motion_code,
  output logic [31:0] pos_ref
);
  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic w_lane0;
    logic b_vld;
    logic [1:0] b_resp;
    logic ar_rdy;
    logic r_vld;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic halt;
    logic drive_en;
    logic temp_warn;
    logic temp_err;
    logic cur_fault;
    logic volt_err;
    logic sup_warn;
    logic sup_fault;
    logic overdrive;
    logic err_state;
    logic limit_hit;
    logic limit_en;
    logic overload_d;
    logic [7:0] last_cmd;
    logic [7:0] last_res;
    logic motion_vld;
    logic [7:0] motion_code;
    logic [16:0] ms_div;
    logic [31:0] uptime;
    logic [fhs_pkg::EV_N-1:0] ev_pend;
    logic [fhs_pkg::LOG_DEPTH-1:0][39:0] log_mem;
    logic [3:0] log_wr;
    logic [4:0] log_cnt;
    logic [3:0] log_sel;
    logic [31:0] pos_ref;
  } fhs_state_t;

  fhs_state_t st_ff;
  fhs_state_t nxt_st;
  logic wr_do;
  logic cmd_fire;
  logic [7:0] cmd_code;
  logic ack_ok;
  logic halt_cause;
  logic log_pop;
  logic [2:0] log_code;
  logic [3:0] log_phys;
  logic [31:0] status_word;
  logic [31:0] stamp;

  always_comb begin
    status_word = '0;
    status_word[fhs_pkg::ST_HALT] = st_ff.halt;
    status_word[fhs_pkg::ST_SUP_WARN] = st_ff.sup_warn;
    status_word[fhs_pkg::ST_SUP_FAULT] = st_ff.sup_fault;
    status_word[fhs_pkg::ST_OVERDRIVE] = st_ff.overdrive;
    status_word[fhs_pkg::ST_TEMP_WARN] = st_ff.temp_warn;
    status_word[fhs_pkg::ST_TEMP_ERR] = st_ff.temp_err;
    status_word[fhs_pkg::ST_CUR_FAULT] = st_ff.cur_fault;
    status_word[fhs_pkg::ST_VOLT_ERR] = st_ff.volt_err;
    status_word[fhs_pkg::ST_ERR_STATE] = st_ff.err_state;
    status_word[fhs_pkg::ST_LIMIT] = st_ff.limit_hit;
  end

  always_comb begin
    nxt_st = st_ff;
    // Write channel capture
    if (s_axi_awvalid && st_ff.aw_rdy) begin
      nxt_st.aw_full = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.w_rdy) begin
      nxt_st.w_full = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_lane0 = s_axi_wstrb[0];
    end
    if (st_ff.b_vld && s_axi_bready) begin
      nxt_st.b_vld = 1'b0;
    end
    wr_do = st_ff.aw_full && st_ff.w_full && !st_ff.b_vld;
    cmd_fire = 1'b0;
    cmd_code = st_ff.w_data[7:0];
    if (wr_do) begin
      nxt_st.aw_full = 1'b0;
      nxt_st.w_full = 1'b0;
      nxt_st.b_vld = 1'b1;
      nxt_st.b_resp = fhs_pkg::RESP_OKAY;
      unique case (st_ff.aw_addr)
        fhs_pkg::OFF_CTRL: begin
          if (st_ff.w_lane0) begin
            nxt_st.limit_en = st_ff.w_data[0];
          end
        end
        fhs_pkg::OFF_CMD: begin
          cmd_fire = st_ff.w_lane0;
        end
        fhs_pkg::OFF_LOG_SEL: begin
          if (st_ff.w_lane0) begin
            nxt_st.log_sel = st_ff.w_data[3:0];
          end
        end
        fhs_pkg::OFF_STATUS, fhs_pkg::OFF_SENSE, fhs_pkg::OFF_UPTIME,
        fhs_pkg::OFF_LOG_TS, fhs_pkg::OFF_LOG_CODE, fhs_pkg::OFF_POS_REF: begin
        end
        default: begin
          nxt_st.b_resp = fhs_pkg::RESP_SLVERR;
        end
      endcase
    end
    nxt_st.aw_rdy = !nxt_st.aw_full;
    nxt_st.w_rdy = !nxt_st.w_full;

    if (st_ff.ms_div == 17'(MS_CYCLES - 1)) begin
      nxt_st.ms_div = '0;
      nxt_st.uptime = st_ff.uptime + 32'h1;
    end else begin
      nxt_st.ms_div = st_ff.ms_div + 17'h1;
    end
    nxt_st.temp_warn = temp_c > fhs_pkg::TEMP_WARN_C;
    nxt_st.temp_err = temp_c >= fhs_pkg::TEMP_ERR_C;
    nxt_st.overload_d = overload;
    if (st_ff.sup_fault) begin
      nxt_st.sup_fault = supply_dv <= fhs_pkg::V_FAULT_LO + fhs_pkg::V_HYST
        || supply_dv >= fhs_pkg::V_FAULT_HI - fhs_pkg::V_HYST;
    end else begin
      nxt_st.sup_fault = supply_dv <= fhs_pkg::V_FAULT_LO
        || supply_dv >= fhs_pkg::V_FAULT_HI;
    end
    if (st_ff.sup_warn) begin
      nxt_st.sup_warn = supply_dv <= fhs_pkg::V_WARN_LO + fhs_pkg::V_HYST
        || supply_dv >= fhs_pkg::V_WARN_HI - fhs_pkg::V_HYST;
    end else begin
      nxt_st.sup_warn = supply_dv <= fhs_pkg::V_WARN_LO
        || supply_dv >= fhs_pkg::V_WARN_HI;
    end
    if (homed_valid) begin
      nxt_st.pos_ref = homed_pos;
    end
    ack_ok = !st_ff.temp_err && !overload && !st_ff.sup_fault;
    nxt_st.motion_vld = 1'b0;
    if (cmd_fire) begin
      nxt_st.last_cmd = cmd_code;
      nxt_st.last_res = fhs_pkg::RES_OK;
      unique case (cmd_code)
        fhs_pkg::CMD_ACK: begin
          if (ack_ok) begin
            nxt_st.halt = 1'b0;
            nxt_st.cur_fault = 1'b0;
            nxt_st.volt_err = 1'b0;
            nxt_st.err_state = 1'b0;
            nxt_st.limit_hit = 1'b0;
          end else begin
            nxt_st.last_res = fhs_pkg::RES_ACK_REFUSED;
          end
        end
        fhs_pkg::CMD_HALT: begin
        end
        fhs_pkg::CMD_OVERDRIVE: begin
          nxt_st.overdrive = 1'b1;
        end
        fhs_pkg::CMD_HOMING, fhs_pkg::CMD_PREPOS, fhs_pkg::CMD_GRASP,
        fhs_pkg::CMD_RELEASE: begin
          if (st_ff.halt) begin
            nxt_st.last_res = fhs_pkg::RES_DENIED;
          end else begin
            nxt_st.motion_vld = 1'b1;
            nxt_st.motion_code = cmd_code;
          end
        end
        default: begin
          nxt_st.last_res = fhs_pkg::RES_UNKNOWN;
        end
      endcase
    end
    nxt_st.cur_fault |= overload && !st_ff.overload_d;
    nxt_st.volt_err |= nxt_st.sup_fault && !st_ff.sup_fault;
    nxt_st.err_state |= cmd_fail_ack;
    nxt_st.limit_hit |= limit_cross && st_ff.limit_en;
    halt_cause = (nxt_st.temp_err && !st_ff.temp_err)
      || (overload && !st_ff.overload_d)
      || (nxt_st.sup_fault && !st_ff.sup_fault)
      || cmd_fail_ack || (limit_cross && st_ff.limit_en)
      || (cmd_fire && cmd_code == fhs_pkg::CMD_HALT);
    nxt_st.halt |= halt_cause;
    nxt_st.drive_en = !nxt_st.halt;

    log_pop = |st_ff.ev_pend;
    log_code = '0;
    for (int i = fhs_pkg::EV_N - 1; i >= 0; i--) begin
      if (st_ff.ev_pend[i]) begin
        log_code = 3'(i);
      end
    end
    if (log_pop) begin
      nxt_st.ev_pend[log_code] = 1'b0;
    end
    nxt_st.ev_pend[fhs_pkg::EV_HALT] |= nxt_st.halt && !st_ff.halt;
    nxt_st.ev_pend[fhs_pkg::EV_TWARN] |= nxt_st.temp_warn && !st_ff.temp_warn;
    nxt_st.ev_pend[fhs_pkg::EV_TERR] |= nxt_st.temp_err && !st_ff.temp_err;
    nxt_st.ev_pend[fhs_pkg::EV_CUR] |= overload && !st_ff.overload_d;
    nxt_st.ev_pend[fhs_pkg::EV_OVD] |= nxt_st.overdrive && !st_ff.overdrive;
    stamp = tod_valid ? tod_ms : st_ff.uptime;
    if (log_pop) begin
      nxt_st.log_mem[st_ff.log_wr] = {5'h0, log_code + 3'h1, stamp};
      nxt_st.log_wr = st_ff.log_wr + 4'h1;
      if (st_ff.log_cnt != 5'(fhs_pkg::LOG_DEPTH)) begin
        nxt_st.log_cnt = st_ff.log_cnt + 5'h1;
      end
    end

    // Read channel
    log_phys = st_ff.log_sel;
    if (st_ff.log_cnt == 5'(fhs_pkg::LOG_DEPTH)) begin
      log_phys = st_ff.log_wr + st_ff.log_sel;
    end
    if (st_ff.r_vld && s_axi_rready) begin
      nxt_st.r_vld = 1'b0;
      nxt_st.ar_rdy = 1'b1;
    end
    if (s_axi_arvalid && st_ff.ar_rdy) begin
      nxt_st.r_vld = 1'b1;
      nxt_st.ar_rdy = 1'b0;
      nxt_st.r_resp = fhs_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        fhs_pkg::OFF_STATUS: nxt_st.r_data = status_word;
        fhs_pkg::OFF_CTRL: nxt_st.r_data = {31'h0, st_ff.limit_en};
        fhs_pkg::OFF_CMD: nxt_st.r_data = {16'h0, st_ff.last_res, st_ff.last_cmd};
        fhs_pkg::OFF_SENSE: nxt_st.r_data = {14'h0, supply_dv, temp_c};
        fhs_pkg::OFF_UPTIME: nxt_st.r_data = st_ff.uptime;
        fhs_pkg::OFF_LOG_SEL: nxt_st.r_data = {11'h0, st_ff.log_cnt, 12'h0, st_ff.log_sel};
        fhs_pkg::OFF_LOG_TS: nxt_st.r_data = st_ff.log_mem[log_phys][31:0];
        fhs_pkg::OFF_LOG_CODE: nxt_st.r_data = {24'h0, st_ff.log_mem[log_phys][39:32]};
        fhs_pkg::OFF_POS_REF: nxt_st.r_data = st_ff.pos_ref;
        default: begin
          nxt_st.r_data = '0;
          nxt_st.r_resp = fhs_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.aw_rdy <= 1'b1;
      st_ff.w_rdy <= 1'b1;
      st_ff.ar_rdy <= 1'b1;
      st_ff.drive_en <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.aw_rdy;
  assign s_axi_wready = st_ff.w_rdy;
  assign s_axi_bvalid = st_ff.b_vld;
  assign s_axi_bresp = st_ff.b_resp;
  assign s_axi_arready = st_ff.ar_rdy;
  assign s_axi_rvalid = st_ff.r_vld;
  assign s_axi_rdata = st_ff.r_data;
  assign s_axi_rresp = st_ff.r_resp;
  assign drive_en = st_ff.drive_en;
  assign motion_valid = st_ff.motion_vld;
  assign motion_code = st_ff.motion_code;
  assign pos_ref = st_ff.pos_ref;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_halt_drive_off: assert property (st_ff.halt |-> !st_ff.drive_en)
    else $error("drive powered while halted");
  a_motion_denied: assert property (cmd_fire && st_ff.halt
    && cmd_code == fhs_pkg::CMD_GRASP |=> st_ff.last_res == fhs_pkg::RES_DENIED
    && !st_ff.motion_vld)
    else $error("motion accepted while halted");
  a_halt_held: assert property (st_ff.halt
    && !(cmd_fire && cmd_code == fhs_pkg::CMD_ACK) |=> st_ff.halt)
    else $error("halt dropped without ack");
  a_temp_halt: assert property (temp_c >= fhs_pkg::TEMP_ERR_C && !st_ff.temp_err
    |=> st_ff.halt && st_ff.temp_err ##[0:4] log_pop && log_code == 3'h2)
    else $error("temperature error did not halt");
  a_ack_hot: assert property (cmd_fire && cmd_code == fhs_pkg::CMD_ACK && st_ff.halt
    && st_ff.temp_err |=> st_ff.halt && st_ff.last_res == fhs_pkg::RES_ACK_REFUSED)
    else $error("ack taken while hot");
  a_supply_hyst: assert property (st_ff.sup_fault && supply_dv > fhs_pkg::V_FAULT_LO
    && supply_dv <= fhs_pkg::V_FAULT_LO + fhs_pkg::V_HYST |=> st_ff.sup_fault)
    else $error("supply fault released inside hysteresis");
  a_supply_fault: assert property (supply_dv >= fhs_pkg::V_FAULT_HI
    |=> st_ff.sup_fault && st_ff.sup_warn && st_ff.halt)
    else $error("supply fault missed");
  a_cur_fault: assert property ($rose(overload) |=> st_ff.cur_fault && st_ff.halt)
    else $error("overload did not latch");
  a_log_wrap: assert property (log_pop && st_ff.log_cnt == 5'(fhs_pkg::LOG_DEPTH)
    |=> st_ff.log_cnt == 5'(fhs_pkg::LOG_DEPTH)
    && st_ff.log_wr == $past(st_ff.log_wr) + 4'h1)
    else $error("log wrap wrong");
  a_overdrive_log: assert property (cmd_fire && cmd_code == fhs_pkg::CMD_OVERDRIVE
    && !st_ff.overdrive |=> st_ff.overdrive ##[0:5] log_pop && log_code == 3'h4)
    else $error("overdrive not logged");
  c_halt_ack: cover property (st_ff.halt ##[1:100] !st_ff.halt);
  c_log_full: cover property (st_ff.log_cnt == 5'(fhs_pkg::LOG_DEPTH) && log_pop);
  c_motion_ok: cover property (st_ff.motion_vld);
endmodule
`default_nettype wire

// ---- fhs_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module fhs_host_model (
  input wire logic core_clk,
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  output logic timed_out
);
  initial begin
    awvalid = 1'b0;
    awaddr = 8'h00;
    wvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    bready = 1'b0;
    arvalid = 1'b0;
    araddr = 8'h00;
    rready = 1'b0;
    timed_out = 1'b0;
  end
  // Address and data offered together, each released when taken
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    done = 1'b0;
    r = 2'h3;
    @(posedge core_clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    for (n = 0; n < 64 && !done; n++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        r = bresp;
        done = 1'b1;
      end
    end
    if (!done) timed_out <= 1'b1;
  endtask
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    done = 1'b0;
    d = 32'h0;
    r = 2'h3;
    @(posedge core_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (n = 0; n < 64 && !done; n++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        done = 1'b1;
      end
    end
    if (!done) timed_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- fault_halt_supervisor_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module fault_halt_supervisor_tb;
  logic core_clk, reset, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, timed_out, overload, limit_cross, cmd_fail_ack, homed_valid, tod_valid;
  logic drive_en, motion_valid;
  logic [7:0] awaddr, araddr, temp_c, motion_code;
  logic [31:0] wdata, rdata, homed_pos, tod_ms, pos_ref, d, up0, up1;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [9:0] supply_dv;
  int mismatches = 0;
  int compares = 0;
  int mv_cnt = 0;
  int i;
  localparam logic [7:0] MC [4] = '{fhs_pkg::CMD_HOMING, fhs_pkg::CMD_PREPOS,
                                    fhs_pkg::CMD_GRASP, fhs_pkg::CMD_RELEASE};
  fhs_supervisor #(.MS_CYCLES(10)) u_dut (.core_clk(core_clk), .reset(reset),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .temp_c(temp_c), .supply_dv(supply_dv), .overload(overload), .limit_cross(limit_cross),
    .cmd_fail_ack(cmd_fail_ack), .homed_valid(homed_valid), .homed_pos(homed_pos),
    .tod_valid(tod_valid), .tod_ms(tod_ms), .drive_en(drive_en),
    .motion_valid(motion_valid), .motion_code(motion_code), .pos_ref(pos_ref));
  fhs_host_model u_host (.core_clk(core_clk), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .timed_out(timed_out));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (motion_valid === 1'b1) mv_cnt <= mv_cnt + 1;
  end
  always @(posedge timed_out) begin
    mismatches++;
    summarize();
  end
  function automatic logic [31:0] b(input int k);
    return 32'h1 << k;
  endfunction
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    u_host.write(a, v, rs);
    `CHK(rs, fhs_pkg::RESP_OKAY)
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic [1:0] rs;
    u_host.read(a, v, rs);
    `CHK(rs, fhs_pkg::RESP_OKAY)
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] res);
    logic [31:0] v;
    wr(fhs_pkg::OFF_CMD, {24'h0, c});
    rd(fhs_pkg::OFF_CMD, v);
    `CHK(v[15:0], {res, c})
  endtask
  task automatic st(input logic [31:0] e);
    logic [31:0] v;
    repeat (4) @(posedge core_clk);
    rd(fhs_pkg::OFF_STATUS, v);
    `CHK(v, e)
  endtask
  task automatic log_at(input int k, input logic [7:0] c, output logic [31:0] ts);
    logic [31:0] v;
    repeat (8) @(posedge core_clk);
    rd(fhs_pkg::OFF_LOG_SEL, v);
    wr(fhs_pkg::OFF_LOG_SEL, 32'(v[20:16]) - 32'(k));
    rd(fhs_pkg::OFF_LOG_CODE, v);
    `CHK(v[7:0], c)
    rd(fhs_pkg::OFF_LOG_TS, ts);
  endtask
  initial begin
    reset = 1'b1;
    temp_c = 8'h19;
    supply_dv = 10'h0f0;
    {overload, limit_cross, cmd_fail_ack, homed_valid, tod_valid} = 5'h00;
    homed_pos = 32'h0;
    tod_ms = 32'h0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    st(32'h0);
    `CHK(drive_en, 1'b1)
    u_host.read(8'h40, d, r);
    `CHK(d, 32'h0)
    `CHK(r, fhs_pkg::RESP_SLVERR)
    u_host.write(8'h40, 32'h1, r);
    `CHK(r, fhs_pkg::RESP_SLVERR)
    $display("test reset done");
    for (i = 0; i < 4; i++) cmd(MC[i], fhs_pkg::RES_OK);
    `CHK(mv_cnt, 4)
    `CHK(motion_code, fhs_pkg::CMD_RELEASE)
    cmd(8'h77, fhs_pkg::RES_UNKNOWN);
    $display("test motion done");
    @(posedge core_clk);
    homed_valid <= 1'b1;
    homed_pos <= 32'h0000abcd;
    @(posedge core_clk);
    homed_valid <= 1'b0;
    rd(fhs_pkg::OFF_UPTIME, up0);
    cmd(fhs_pkg::CMD_HALT, fhs_pkg::RES_OK);
    st(b(fhs_pkg::ST_HALT));
    `CHK(drive_en, 1'b0)
    `CHK(pos_ref, 32'h0000abcd)
    for (i = 0; i < 4; i++) cmd(MC[i], fhs_pkg::RES_DENIED);
    `CHK(mv_cnt, 4)
    rd(fhs_pkg::OFF_UPTIME, up1);
    log_at(1, 8'h01, d);
    `CHK((d >= up0) && (d <= up1) && (up1 > up0), 1'b1)
    st(b(fhs_pkg::ST_HALT));
    cmd(fhs_pkg::CMD_ACK, fhs_pkg::RES_OK);
    st(32'h0);
    `CHK(drive_en, 1'b1)
    $display("test halt done");
    temp_c <= 8'h41;
    st(32'h0);
    temp_c <= 8'h42;
    st(b(fhs_pkg::ST_TEMP_WARN));
    temp_c <= 8'h46;
    st(b(fhs_pkg::ST_HALT) | b(fhs_pkg::ST_TEMP_WARN) | b(fhs_pkg::ST_TEMP_ERR));
    log_at(2, 8'h01, d);
    log_at(1, 8'h03, d);
    cmd(fhs_pkg::CMD_ACK, fhs_pkg::RES_ACK_REFUSED);
    temp_c <= 8'h3c;
    cmd(fhs_pkg::CMD_ACK, fhs_pkg::RES_OK);
    st(32'h0);
    $display("test temperature done");
    overload <= 1'b1;
    st(b(fhs_pkg::ST_HALT) | b(fhs_pkg::ST_CUR_FAULT));
    `CHK(drive_en, 1'b0)
    log_at(1, 8'h04, d);
    cmd(fhs_pkg::CMD_ACK, fhs_pkg::RES_ACK_REFUSED);
    overload <= 1'b0;
    cmd(fhs_pkg::CMD_ACK, fhs_pkg::RES_OK);
    st(32'h0);
    $display("test overload done");
    supply_dv <= 10'h0c8;
    st(b(fhs_pkg::ST_HALT) | b(fhs_pkg::ST_SUP_WARN) | b(fhs_pkg::ST_SUP_FAULT)
       | b(fhs_pkg::ST_VOLT_ERR));
    supply_dv <= 10'h0cb;
    cmd(fhs_pkg::CMD_ACK, fhs_pkg::RES_ACK_REFUSED);
    supply_dv <= 10'h0f0;
    cmd(fhs_pkg::CMD_ACK, fhs_pkg::RES_OK);
    st(32'h0);
    supply_dv <= 10'h118;
    st(b(fhs_pkg::ST_HALT) | b(fhs_pkg::ST_SUP_WARN) | b(fhs_pkg::ST_SUP_FAULT)
       | b(fhs_pkg::ST_VOLT_ERR));
    supply_dv <= 10'h115;
    cmd(fhs_pkg::CMD_ACK, fhs_pkg::RES_ACK_REFUSED);
    supply_dv <= 10'h0f0;
    cmd(fhs_pkg::CMD_ACK, fhs_pkg::RES_OK);
    st(32'h0);
    supply_dv <= 10'h0dc;
    st(b(fhs_pkg::ST_SUP_WARN));
    supply_dv <= 10'h0df;
    st(b(fhs_pkg::ST_SUP_WARN));
    supply_dv <= 10'h104;
    st(b(fhs_pkg::ST_SUP_WARN));
    supply_dv <= 10'h0f0;
    st(32'h0);
    $display("test supply done");
    wr(fhs_pkg::OFF_CTRL, 32'h1);
    @(posedge core_clk);
    limit_cross <= 1'b1;
    @(posedge core_clk);
    limit_cross <= 1'b0;
    st(b(fhs_pkg::ST_HALT) | b(fhs_pkg::ST_LIMIT));
    cmd(fhs_pkg::CMD_ACK, fhs_pkg::RES_OK);
    wr(fhs_pkg::OFF_CTRL, 32'h0);
    limit_cross <= 1'b1;
    @(posedge core_clk);
    limit_cross <= 1'b0;
    st(32'h0);
    cmd_fail_ack <= 1'b1;
    @(posedge core_clk);
    cmd_fail_ack <= 1'b0;
    st(b(fhs_pkg::ST_HALT) | b(fhs_pkg::ST_ERR_STATE));
    cmd(fhs_pkg::CMD_ACK, fhs_pkg::RES_OK);
    $display("test limit and error done");
    cmd(fhs_pkg::CMD_OVERDRIVE, fhs_pkg::RES_OK);
    st(b(fhs_pkg::ST_OVERDRIVE));
    log_at(1, 8'h05, d);
    $display("test overdrive done");
    tod_valid <= 1'b1;
    for (i = 0; i < 20; i++) begin
      tod_ms <= 32'(i);
      cmd(fhs_pkg::CMD_HALT, fhs_pkg::RES_OK);
      cmd(fhs_pkg::CMD_ACK, fhs_pkg::RES_OK);
    end
    repeat (8) @(posedge core_clk);
    rd(fhs_pkg::OFF_LOG_SEL, d);
    `CHK(d[20:16], 5'h10)
    log_at(16, 8'h01, d);
    `CHK(d, 32'h4)
    log_at(1, 8'h01, d);
    `CHK(d, 32'h13)
    $display("test log wrap done");
    summarize();
  end
endmodule
`default_nettype wire
